// ---- logic/mism_intc.sv ----
/*
 * Interrupt source and mask registers for the embedded microcontroller.
 * Assumes event inputs are one-cycle pulses or levels synchronous to clk
 * and a register port with read data one cycle after the read strobe.
 */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module mism_intc
    import mism_pkg::*;
(
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Register port.
    input  wire mism_pkg::mism_bus_t       bus,
    output logic [mism_pkg::DATA_W-1:0]    rdata,
    // External interrupt inputs, active high.
    input  wire logic [mism_pkg::N_EXT-1:0] ext_int_in,
    // Packet buffer and engine event pulses.
    input  wire mism_pkg::mism_evt_t       evt,
    // Transmit endpoints.
    input  wire logic [mism_pkg::N_EP-1:0] tx_ep_enable,
    input  wire logic [mism_pkg::N_EP-1:0] tx_queue_drained,
    input  wire logic [mism_pkg::N_EP-1:0] tx_queue_load,
    output logic [mism_pkg::N_EP-1:0]      nak_pending,
    // Bus DMA request status and its mask, one masks.
    input  wire logic [mism_pkg::DMA_W-1:0] dma_req_status,
    input  wire logic [mism_pkg::DMA_W-1:0] dma_req_mask,
    // Serial engine idle level and receive overrun cause level.
    input  wire logic                      engine_idle,
    input  wire logic                      overrun_cause,
    output logic                           rx_blocked,
    output logic                           release_partial,
    // Wakeup sources.
    input  wire logic [mism_pkg::WAKE_W-1:0] wakeup_source_a,
    input  wire logic [mism_pkg::WAKE_W-1:0] wakeup_source_b,
    // Interrupt request to the core.
    output logic                           irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode.

    logic hit_src0;
    logic hit_mask0;
    logic hit_src1;
    logic hit_mask1;
    logic rd_src0;
    logic rd_src1;

    assign hit_src0  = bus.addr == OFS_SRC0;
    assign hit_mask0 = bus.addr == OFS_MASK0;
    assign hit_src1  = bus.addr == OFS_SRC1;
    assign hit_mask1 = bus.addr == OFS_MASK1;
    assign rd_src0   = bus.rd && hit_src0;
    assign rd_src1   = bus.rd && hit_src1;

    ////////////////////////////////////////////////////////////////////////
    // Edge history for level sources.

    logic [DMA_W-1:0]  dma_prev;
    logic [WAKE_W-1:0] wake_a_prev;
    logic [WAKE_W-1:0] wake_b_prev;
    logic              idle_prev;
    logic              cause_prev;

    always_ff @(posedge clk) begin
        if (rst) begin
            dma_prev    <= '0;
            wake_a_prev <= '0;
            wake_b_prev <= '0;
            idle_prev   <= 1'b1;
            cause_prev  <= 1'b0;
        end else begin
            dma_prev    <= dma_req_status;
            wake_a_prev <= wakeup_source_a;
            wake_b_prev <= wakeup_source_b;
            idle_prev   <= engine_idle;
            cause_prev  <= overrun_cause;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Set terms of both source banks.

    logic [DATA_W-1:0] set0;
    logic [DATA_W-1:0] set1;
    logic              dma_rise;
    logic              wake_rise;
    logic              ovrn_rise;

    assign dma_rise  = |(dma_req_status & ~dma_prev & ~dma_req_mask);
    assign wake_rise = |(wakeup_source_a & ~wake_a_prev)
                     | |(wakeup_source_b & ~wake_b_prev);
    assign ovrn_rise = overrun_cause && !cause_prev;

    always_comb begin
        set0 = '0;
        set0[BIT_EXT_LO +: N_EXT] = ext_int_in;
        set0[BIT_RXQ]     = evt.rx_queued;
        set0[BIT_TXEMPTY] = |(tx_queue_drained & tx_ep_enable);
        set0[BIT_TXDONE]  = evt.tx_done;
        set0[BIT_DMA]     = dma_rise;
    end

    always_comb begin
        set1 = '0;
        set1[BIT_TXN_END] = engine_idle && !idle_prev;
        set1[BIT_SOF]   = evt.frame_count_wr;
        set1[BIT_SOFTWARE_ALLOCATION_DONE_FLAG] = evt.software_allocation_done_flag_done && !evt.software_allocation_done_flag_by_hw;
        set1[BIT_OVRN]  = ovrn_rise;
        set1[BIT_WAKE]  = wake_rise;
    end

    ////////////////////////////////////////////////////////////////////////
    // Source registers: cleared by a read or by writing ones.

    logic [DATA_W-1:0] src0;
    logic [DATA_W-1:0] src1_raw;
    logic [DATA_W-1:0] src1;
    logic [DATA_W-1:0] w1c0;
    logic [DATA_W-1:0] w1c1;

    assign w1c0 = (bus.wr && hit_src0) ? bus.wdata : '0;
    assign w1c1 = (bus.wr && hit_src1) ? bus.wdata : '0;

    mism_flag_bank #(
        .W        (DATA_W)
    ) u_src0 (
        .clk      (clk),
        .rst      (rst),
        .set      (set0),
        .clr_all  (rd_src0),
        .clr_bits (w1c0),
        .flags    (src0)
    );

    mism_flag_bank #(
        .W        (DATA_W)
    ) u_src1 (
        .clk      (clk),
        .rst      (rst),
        .set      (set1),
        .clr_all  (rd_src1),
        .clr_bits (w1c1),
        .flags    (src1_raw)
    );

    assign src1 = src1_raw & BANK1_USE;

    ////////////////////////////////////////////////////////////////////////
    // Mask registers.

    logic [DATA_W-1:0] mask0;
    logic [DATA_W-1:0] mask1;

    always_ff @(posedge clk) begin
        if (rst) begin
            mask0 <= RST_MASK;
        end else if (bus.wr && hit_mask0) begin
            mask0 <= bus.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask1 <= RST_MASK;
        end else if (bus.wr && hit_mask1) begin
            mask1 <= bus.wdata | ~BANK1_USE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid in the cycle after the strobe.

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else if (bus.rd) begin
            case (1'b1)
                hit_src0:  rdata <= src0;
                hit_mask0: rdata <= mask0;
                hit_src1:  rdata <= src1;
                hit_mask1: rdata <= mask1;
                default:   rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request.

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(src0 & ~mask0) | |(src1 & ~mask1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Endpoint NAK state: set when an enabled endpoint's queue drains, cleared by a new load.

    always_ff @(posedge clk) begin
        if (rst) begin
            nak_pending <= '0;
        end else begin
            nak_pending <= (nak_pending & ~tx_queue_load)
                         | (tx_queue_drained & tx_ep_enable);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive overrun recovery: hold off reception until the cause clears,
    // then release partially allocated packets once.

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_blocked      <= 1'b0;
            release_partial <= 1'b0;
        end else begin
            rx_blocked      <= overrun_cause;
            release_partial <= cause_prev && !overrun_cause;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ext_level_seen: assert property (
        ext_int_in[2] |=> src0[BIT_EXT_LO + 2])
        else $error("external input not shown in source0");

    a_rxq_sets: assert property (
        evt.rx_queued |=> src0[BIT_RXQ])
        else $error("receive queued flag not set");

    a_txempty_sets: assert property (
        (|(tx_queue_drained & tx_ep_enable)) |=> src0[BIT_TXEMPTY])
        else $error("transmit empty flag not set");

    a_txempty_disabled: assert property (
        !$past(src0[BIT_TXEMPTY]) && $past(!(|(tx_queue_drained & tx_ep_enable)))
        && !$past(bus.wr) |-> !src0[BIT_TXEMPTY])
        else $error("transmit empty flag set without enabled drain");

    a_txdone_sets: assert property (
        evt.tx_done |=> src0[BIT_TXDONE])
        else $error("transmit done flag not set");

    a_dma_masked: assert property (
        !src0[BIT_DMA] && ((dma_req_status & ~dma_req_mask) == 8'h00)
        |=> !src0[BIT_DMA])
        else $error("masked dma change set the flag");

    a_dma_rearm: assert property (
        rd_src0 ##1 (dma_req_status[0] && !$past(dma_req_status[0])
        && !dma_req_mask[0]) |=> src0[BIT_DMA])
        else $error("dma flag not rearmed after read");

    a_read_clears: assert property (
        rd_src1 && set1 == 8'h00 |=> src1 == 8'h00)
        else $error("source1 not cleared by read");

    a_read_returns: assert property (
        rd_src0 |=> rdata == $past(src0))
        else $error("read data not the pre-clear source0");

    a_mask_gates: assert property (
        ((mask0 == 8'hFF) && (mask1 == 8'hFF)) [*2] |-> !irq)
        else $error("interrupt raised while fully masked");

    a_irq_follows: assert property (
        (|(src0 & ~mask0)) |=> irq)
        else $error("unmasked source0 bit did not raise interrupt");

    a_txn_end_sets: assert property (
        engine_idle && !idle_prev |=> src1[BIT_TXN_END])
        else $error("end of transaction flag not set");

    a_sof_sets: assert property (
        evt.frame_count_wr |=> src1[BIT_SOF])
        else $error("start of frame flag not set");

    a_software_allocation_done_flag_hw_quiet: assert property (
        !src1[BIT_SOFTWARE_ALLOCATION_DONE_FLAG] && evt.software_allocation_done_flag_by_hw && !bus.wr |=> !src1[BIT_SOFTWARE_ALLOCATION_DONE_FLAG])
        else $error("hardware allocation set the flag");

    a_ovrn_recover: assert property (
        $fell(overrun_cause) && !$past(rst) |=> release_partial && !rx_blocked)
        else $error("overrun recovery not signalled");

    a_wake_sets: assert property (
        $rose(wakeup_source_b[3]) |=> src1[BIT_WAKE])
        else $error("wakeup flag not set");

    a_bank1_reserved: assert property (
        rd_src1 |=> rdata[7:5] == 3'h0)
        else $error("reserved source1 bits read nonzero");

    a_nak_after_drain: assert property (
        tx_queue_drained[5] && tx_ep_enable[5] && !tx_queue_load[5]
        |=> nak_pending[5] until tx_queue_load[5])
        else $error("endpoint nak not held");

    c_irq_raised:  cover property (!irq ##1 irq);
    c_read_clear:  cover property (rd_src0 && src0 != 8'h00);
    c_set_on_read: cover property (rd_src1 && set1 != 8'h00);
    c_recovery:    cover property (ovrn_rise ##[1:20] release_partial);

endmodule // mism_intc

`default_nettype wire

// ---- shared/mism_pkg.sv ----
/*
 * Constants, types and register map of the microcontroller interrupt source
 * and mask block. Assumes a byte-wide register port at the offsets below.
 */

package mism_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int N_EXT  = 4;
    localparam int N_EP   = 16;
    localparam int DMA_W  = 8;
    localparam int WAKE_W = 8;

    localparam logic [ADDR_W-1:0] OFS_SRC0  = 16'h7F00;
    localparam logic [ADDR_W-1:0] OFS_MASK0 = 16'h7F01;
    localparam logic [ADDR_W-1:0] OFS_SRC1  = 16'h7F02;
    localparam logic [ADDR_W-1:0] OFS_MASK1 = 16'h7F03;

    localparam logic [DATA_W-1:0] RST_SRC   = 8'h00;
    localparam logic [DATA_W-1:0] RST_MASK  = 8'hFF;
    localparam logic [DATA_W-1:0] BANK1_USE = 8'h1F;

    localparam int BIT_EXT_LO  = 4;
    localparam int BIT_RXQ     = 3;
    localparam int BIT_TXEMPTY = 2;
    localparam int BIT_TXDONE  = 1;
    localparam int BIT_DMA     = 0;
    localparam int BIT_TXN_END = 4;
    localparam int BIT_SOF     = 3;
    localparam int BIT_SOFTWARE_ALLOCATION_DONE_FLAG   = 2;
    localparam int BIT_OVRN    = 1;
    localparam int BIT_WAKE    = 0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } mism_bus_t;

    typedef struct packed {
        logic rx_queued;
        logic tx_done;
        logic frame_count_wr;
        logic software_allocation_done_flag_done;
        logic software_allocation_done_flag_by_hw;
    } mism_evt_t;

endpackage

// ---- logic/mism_flag_bank.sv ----
/*
 * A bank of sticky flags: set pulses, clear on read, clear by writing ones.
 * Assumes all inputs are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module mism_flag_bank #(
    parameter int W = 8
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst,
    // Set and clear requests.
    input  wire logic [W-1:0] set,
    input  wire logic         clr_all,
    input  wire logic [W-1:0] clr_bits,
    // Flag state.
    output logic      [W-1:0] flags
);

    logic [W-1:0] next_flags;

    // A set in the same cycle as a clear keeps the flag set.
    always_comb begin
        next_flags = flags & ~clr_bits;
        if (clr_all) begin
            next_flags = '0;
        end
        next_flags = next_flags | set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

endmodule // mism_flag_bank

`default_nettype wire

// ---- bench/mism_core_model.sv ----
/*
 * Microcontroller core model: services the interrupt request and otherwise
 * makes random register accesses. Assumes it owns the register port when en.
 */
`timescale 1ns/1ps
`default_nettype none

module mism_core_model
    import mism_pkg::*;
(
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                rst,
    // Enable and interrupt request.
    input  wire logic                en,
    input  wire logic                irq,
    // Register port towards the block.
    output var mism_pkg::mism_bus_t  bus
);
    import mism_pkg::*;

    int        seed = 32'h741F;
    int        r;
    logic      svc = 1'b0;
    mism_bus_t nb;

    initial bus = '0;

    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        r = $random(seed);
        nb = '0;
        if (rst || !en) begin
            svc <= 1'b0;
        end else if (svc || (irq && r[0])) begin
            // Both sources are read in turn, since each read discards what it showed.
            nb.rd = 1'b1;
            nb.addr = svc ? OFS_SRC1 : OFS_SRC0;
            svc <= !svc;
        end else if (r[1]) begin
            nb.addr = OFS_SRC0 + 16'(r[10:8] % 3'h5);
            nb.wdata = r[23:16];
            nb.wr = r[2];
            nb.rd = !r[2];
        end
        bus <= nb;
    end
endmodule // mism_core_model

`default_nettype wire

// ---- bench/tb.sv ----
/*
 * Self-checking bench for the interrupt source and mask block with a cycle
 * model of the flags. Assumes the package and the core model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    import mism_pkg::*;

    localparam int LIMIT = 12000;

    logic              clk;
    logic              rst;
    logic              core_en;
    logic              drive;
    logic              chk;
    mism_bus_t         tb_bus;
    mism_bus_t         core_bus;
    mism_bus_t         bus;
    logic [7:0]        rdata;
    logic [3:0]        ext_int_in;
    mism_evt_t         evt;
    logic [15:0]       tx_ep_enable;
    logic [15:0]       tx_queue_drained;
    logic [15:0]       tx_queue_load;
    logic [15:0]       nak_pending;
    logic [7:0]        dma_req_status;
    logic [7:0]        dma_req_mask;
    logic              engine_idle;
    logic              overrun_cause;
    logic              rx_blocked;
    logic              release_partial;
    logic [7:0]        wakeup_source_a;
    logic [7:0]        wakeup_source_b;
    logic              irq;
    int                seed = 32'h741F;
    int                failures = 0;
    int                n_compared = 0;
    int                cyc = 0;
    int                r1, r2, r3;
    logic [7:0]        m_src0, m_src1, m_mask0, m_mask1, m_rdata, ev0, ev1, c0, c1;
    logic [15:0]       m_nak;
    logic [7:0]        p_dma, p_wa, p_wb;
    logic              m_irq, m_blk, m_rel, p_idle, p_ovr;

    mism_intc u_mism_intc (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .ext_int_in(ext_int_in), .evt(evt), .tx_ep_enable(tx_ep_enable),
        .tx_queue_drained(tx_queue_drained), .tx_queue_load(tx_queue_load),
        .nak_pending(nak_pending), .dma_req_status(dma_req_status),
        .dma_req_mask(dma_req_mask), .engine_idle(engine_idle),
        .overrun_cause(overrun_cause), .rx_blocked(rx_blocked),
        .release_partial(release_partial), .wakeup_source_a(wakeup_source_a),
        .wakeup_source_b(wakeup_source_b), .irq(irq));

    mism_core_model u_mism_core_model (.clk(clk), .rst(rst), .en(core_en), .irq(irq),
        .bus(core_bus));

    assign bus = core_en ? core_bus : tb_bus;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        tb_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        tb_bus <= '0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        tb_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        tb_bus <= '0;
        @(negedge clk);
        cmp8(rdata, exp, "register read");
        @(posedge clk);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Random traffic on every event input; level inputs toggle now and then.
    always @(posedge clk) begin
        r1 = $random(seed);
        r2 = $random(seed);
        r3 = $random(seed);
        if (drive) begin
            ext_int_in <= r1[3:0] & r1[7:4] & r1[11:8];
            evt <= mism_evt_t'(r1[16:12] & r1[21:17] & r1[26:22]);
            tx_queue_drained <= r2[15:0] & r3[15:0] & r3[31:16];
            tx_queue_load <= r2[31:16] & r3[15:0] & ~r3[31:16];
            dma_req_status <= dma_req_status ^ (r1[31:24] & r2[7:0] & r3[23:16]);
            engine_idle <= engine_idle ^ (r1[27] & r2[3]);
            overrun_cause <= overrun_cause ^ (r1[28] & r2[9]);
            wakeup_source_a <= wakeup_source_a ^ (r2[31:24] & r3[7:0] & r1[23:16]);
            wakeup_source_b <= wakeup_source_b ^ (r3[31:24] & r2[15:8] & r1[15:8]);
        end
    end

    // Cycle model: sources set a cycle after their event, irq one cycle later.
    always @(posedge clk) begin
        if (rst) begin
            {m_src0, m_src1, m_rdata, m_nak, p_dma, p_wa, p_wb} = '0;
            {m_mask0, m_mask1} = 16'hFFFF;
            {m_irq, m_blk, m_rel, p_ovr} = 4'h0;
            p_idle = 1'b1;
        end else begin
            ev0 = {ext_int_in, evt.rx_queued, |(tx_queue_drained & tx_ep_enable),
                   evt.tx_done, |(dma_req_status & ~p_dma & ~dma_req_mask)};
            ev1 = {3'h0, engine_idle & ~p_idle, evt.frame_count_wr,
                   evt.software_allocation_done_flag_done & ~evt.software_allocation_done_flag_by_hw, overrun_cause & ~p_ovr,
                   |(wakeup_source_a & ~p_wa) | |(wakeup_source_b & ~p_wb)};
            m_irq = |(m_src0 & ~m_mask0) | |(m_src1 & ~m_mask1);
            m_rdata = 8'h00;
            c0 = 8'h00;
            c1 = 8'h00;
            if (bus.rd) begin
                case (bus.addr)
                    OFS_SRC0: m_rdata = m_src0;
                    OFS_MASK0: m_rdata = m_mask0;
                    OFS_SRC1: m_rdata = m_src1;
                    OFS_MASK1: m_rdata = m_mask1;
                    default: m_rdata = 8'h00;
                endcase
            end
            if (bus.addr == OFS_SRC0) c0 = bus.rd ? 8'hFF : (bus.wr ? bus.wdata : 8'h00);
            if (bus.addr == OFS_SRC1) c1 = bus.rd ? 8'hFF : (bus.wr ? bus.wdata : 8'h00);
            if (bus.wr && bus.addr == OFS_MASK0) m_mask0 = bus.wdata;
            if (bus.wr && bus.addr == OFS_MASK1) m_mask1 = bus.wdata | 8'hE0;
            m_src0 = (m_src0 & ~c0) | ev0;
            m_src1 = (m_src1 & ~c1) | ev1;
            m_nak = (m_nak & ~tx_queue_load) | (tx_queue_drained & tx_ep_enable);
            m_blk = overrun_cause;
            m_rel = p_ovr & ~overrun_cause;
            {p_dma, p_idle, p_ovr, p_wa, p_wb} = {dma_req_status, engine_idle,
                overrun_cause, wakeup_source_a, wakeup_source_b};
        end
    end

    always @(negedge clk) begin
        if (chk) begin
            cmp8(rdata, m_rdata, "rdata");
            cmp1(irq, m_irq, "irq");
            cmp1(rx_blocked, m_blk, "rx_blocked");
            cmp1(release_partial, m_rel, "release_partial");
            cmp16(nak_pending, m_nak, "nak");
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            failures++;
            $display("mismatch at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        {rst, core_en, drive, chk, tb_bus, ext_int_in, evt} = {1'b1, 4'h0, 25'h0, 4'h0, 5'h0};
        {tx_queue_drained, tx_queue_load, dma_req_status, overrun_cause} = '0;
        {wakeup_source_a, wakeup_source_b, engine_idle} = {16'h0000, 1'b1};
        tx_ep_enable = 16'h5AF0;
        dma_req_mask = 8'hF0;
        @(posedge clk);
        chk = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(OFS_SRC0, RST_SRC);
        rd_chk(OFS_MASK0, RST_MASK);
        rd_chk(OFS_SRC1, RST_SRC);
        rd_chk(OFS_MASK1, RST_MASK);
        wr(OFS_MASK1, 8'h00);
        wr(16'h7F04, 8'h5A);
        rd_chk(OFS_MASK1, 8'hE0);
        rd_chk(16'h7F04, 8'h00);
        rd_chk(OFS_MASK0, RST_MASK);
        wr(OFS_MASK0, 8'hFD);
        evt.tx_done <= 1'b1;
        @(posedge clk);
        evt.tx_done <= 1'b0;
        repeat (2) @(posedge clk);
        rd_chk(OFS_SRC0, 8'h02);
        rd_chk(OFS_SRC0, RST_SRC);
        $display("test registers done, compared %0d", n_compared);
        core_en <= 1'b1;
        drive <= 1'b1;
        repeat (3000) @(posedge clk);
        $display("test random_a done, compared %0d", n_compared);
        // Reset again in mid traffic with new endpoint and DMA masks.
        rst <= 1'b1;
        dma_req_mask <= 8'h0F;
        tx_ep_enable <= 16'hFFFF;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3000) @(posedge clk);
        $display("test random_b done, compared %0d", n_compared);
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
